// File: design/rilm_input_mon.sv
`timescale 1ns/1ps
`include "rilm_params.svh"
module rilm_input_mon
  import rilm_pkg::*;
(
  // Clock and control
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_clk_en,
  // Signal and comparison tick
  input wire logic i_ref_level,
  input wire logic i_ref_tick,
  // Configuration
  input wire logic [7:0] i_prediv,
  input wire logic [7:0] i_reval_count,
  input wire logic i_disable,
  // Status
  output logic o_live,
  output logic o_prediv_pulse
);

  logic level_d_r;
  logic [7:0] pdiv_cnt_r;
  logic seen_r;
  logic [1:0] miss_r;
  logic [7:0] good_r;
  rilm_state_e state_r;
  logic rise;
  logic hit;
  logic [15:0] pdiv_lim;
  logic [15:0] reval_lim;

  // A static input produces no rise and therefore no pulse.
  assign rise = i_ref_level & ~level_d_r;
  assign hit = seen_r | o_prediv_pulse;
  assign pdiv_lim = rilm_eff_ratio({8'h00, i_prediv});
  assign reval_lim = rilm_eff_ratio({8'h00, i_reval_count});

  // ==========================================================
  // Input pre-divider
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      level_d_r <= 1'b0;
      pdiv_cnt_r <= 8'h00;
      o_prediv_pulse <= 1'b0;
    end else if (i_clk_en) begin
      level_d_r <= i_ref_level;
      o_prediv_pulse <= 1'b0;
      if (i_disable) begin
        pdiv_cnt_r <= 8'h00;
      end else if (rise) begin
        if ({8'h00, pdiv_cnt_r} >= pdiv_lim - 16'h0001) begin
          pdiv_cnt_r <= 8'h00;
          o_prediv_pulse <= 1'b1;
        end else begin
          pdiv_cnt_r <= pdiv_cnt_r + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Edge check per comparison window
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      seen_r <= 1'b0;
      miss_r <= 2'h0;
    end else if (i_clk_en) begin
      if (i_disable) begin
        seen_r <= 1'b0;
        miss_r <= 2'h0;
      end else if (i_ref_tick) begin
        seen_r <= 1'b0;
        if (hit) begin
          miss_r <= 2'h0;
        end else if (miss_r != `RILM_MISS_LIMIT) begin
          miss_r <= miss_r + 2'h1;
        end
      end else if (o_prediv_pulse) begin
        seen_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Validity state
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_r <= RILM_ST_VALID;
      good_r <= 8'h00;
      o_live <= 1'b0;
    end else if (i_clk_en) begin
      if (i_disable) begin
        state_r <= RILM_ST_VALID;
        good_r <= 8'h00;
        o_live <= 1'b0;
      end else if (i_ref_tick) begin
        unique case (state_r)
          RILM_ST_VALID: begin
            if (!hit && miss_r == `RILM_MISS_LIMIT - 2'h1) begin
              state_r <= RILM_ST_LOST;
              good_r <= 8'h00;
              o_live <= 1'b1;
            end
          end
          RILM_ST_LOST: begin
            if (!hit) begin
              good_r <= 8'h00;
            end else if ({8'h00, good_r} + 16'h0001 >= reval_lim) begin
              state_r <= RILM_ST_VALID;
              good_r <= 8'h00;
              o_live <= 1'b0;
            end else begin
              good_r <= good_r + 8'h01;
            end
          end
        endcase
      end
    end
  end

  a_miss_sets_loss: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_clk_en && !i_disable && i_ref_tick && !hit && state_r == RILM_ST_VALID
     && miss_r == 2'h2) |=> o_live)
    else $error("loss not raised after third missing edge");

  a_disable_quiet: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_clk_en && i_disable) |=> !o_live)
    else $error("disabled input still reports loss");

  a_hit_resets: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_clk_en && !i_disable && i_ref_tick && hit) |=> (miss_r == 2'h0))
    else $error("miss count not cleared by good edge");

endmodule

// File: design/rilm_top.sv
`timescale 1ns/1ps
`include "rilm_params.svh"
module rilm_top
  import rilm_pkg::*;
(
  // Clock and control
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_clk_en,
  // Reference inputs, sampled as levels
  input wire logic [1:0] i_reference_input,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Status and interrupt
  output logic [1:0] o_input_loss_live_flag,
  output logic [1:0] o_input_loss_latched_flag,
  output logic o_irq,
  output logic o_gpio_loss_n
);

  // ==========================================================
  // Registers
  // ==========================================================
  logic [3:0] ctrl_r;
  logic [15:0] mondiv_r;
  logic [15:0] prediv_r;
  logic [7:0] reval_r;
  logic [1:0] mask_r;
  logic [1:0] latch_nxt;
  logic [1:0] live_d_r;
  logic [1:0] live_rise;
  logic [1:0] latch_clr;
  logic [1:0] input_monitor_disable;
  logic monitor_divider_powerdown;
  logic gpio_irq_mode;
  logic [15:0] mondiv_cnt_r;
  logic ref_tick_r;
  logic bus_req;
  logic wr_en;
  logic [31:0] rd_val;
  logic [31:0] wr_word;
  logic [15:0] mondiv_lim;

  assign input_monitor_disable = ctrl_r[`RILM_CTRL_DIS_LSB +: 2];
  assign monitor_divider_powerdown = ctrl_r[`RILM_CTRL_PD_BIT];
  assign gpio_irq_mode = ctrl_r[`RILM_CTRL_IRQMODE_BIT];
  assign bus_req = i_wb_cyc & i_wb_stb;
  // Writes land on the edge at which the master samples ack.
  assign wr_en = bus_req & i_wb_we & o_wb_ack;
  assign mondiv_lim = rilm_eff_ratio(mondiv_r);
  // The addressed register's current value, with the enabled byte lanes replaced.
  assign wr_word = rilm_lanes(rd_val, i_wb_dat, i_wb_sel);

  // ==========================================================
  // Monitor reference divider
  // ==========================================================
  // Divider runs from the block clock; its largest ratio bounds the slowest input.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      mondiv_cnt_r <= 16'h0000;
      ref_tick_r <= 1'b0;
    end else if (i_clk_en) begin
      ref_tick_r <= 1'b0;
      if (monitor_divider_powerdown) begin
        mondiv_cnt_r <= 16'h0000;
      end else if (mondiv_cnt_r >= mondiv_lim - 16'h0001) begin
        mondiv_cnt_r <= 16'h0000;
        ref_tick_r <= 1'b1;
      end else begin
        mondiv_cnt_r <= mondiv_cnt_r + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Per-input monitors
  // ==========================================================
  for (genvar g = 0; g < 2; g++) begin : g_mon
    rilm_input_mon u_mon (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_clk_en(i_clk_en),
      .i_ref_level(i_reference_input[g]),
      .i_ref_tick(ref_tick_r),
      .i_prediv(prediv_r[g*`RILM_PREDIV1_LSB +: 8]),
      .i_reval_count(reval_r),
      .i_disable(input_monitor_disable[g]),
      .o_live(o_input_loss_live_flag[g]),
      .o_prediv_pulse()
    );
  end

  // ==========================================================
  // Wishbone slave
  // ==========================================================
  always_comb begin
    rd_val = 32'h00000000;
    unique case (i_wb_adr)
      `RILM_OFS_CTRL: rd_val = {28'h0000000, ctrl_r};
      `RILM_OFS_MONDIV: rd_val = {16'h0000, mondiv_r};
      `RILM_OFS_PREDIV: rd_val = {16'h0000, prediv_r};
      `RILM_OFS_REVAL: rd_val = {24'h000000, reval_r};
      `RILM_OFS_STATUS: rd_val = {30'h00000000, o_input_loss_live_flag};
      `RILM_OFS_LATCH: rd_val = {30'h00000000, o_input_loss_latched_flag};
      `RILM_OFS_MASK: rd_val = {30'h00000000, mask_r};
      default: rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else if (i_clk_en) begin
      o_wb_ack <= bus_req & ~o_wb_ack;
      if (bus_req && !o_wb_ack) begin
        o_wb_dat <= i_wb_we ? 32'h00000000 : rd_val;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ctrl_r <= `RILM_RST_CTRL;
      mondiv_r <= `RILM_RST_MONDIV;
      prediv_r <= `RILM_RST_PREDIV;
      reval_r <= `RILM_RST_REVAL;
      mask_r <= `RILM_RST_MASK;
    end else if (i_clk_en && wr_en) begin
      unique case (i_wb_adr)
        `RILM_OFS_CTRL: begin
          ctrl_r <= wr_word[3:0];
        end
        `RILM_OFS_MONDIV: begin
          mondiv_r <= wr_word[15:0];
        end
        `RILM_OFS_PREDIV: begin
          prediv_r <= wr_word[15:0];
        end
        `RILM_OFS_REVAL: begin
          reval_r <= wr_word[7:0];
        end
        `RILM_OFS_MASK: begin
          mask_r <= wr_word[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Latched loss flags and interrupt
  // ==========================================================
  assign live_rise = o_input_loss_live_flag & ~live_d_r;
  assign latch_clr = (wr_en && i_wb_adr == `RILM_OFS_LATCH && i_wb_sel[0]) ?
                     i_wb_dat[1:0] : 2'h0;
  // A loss that arrives with its clear still sets the flag.
  assign latch_nxt = (o_input_loss_latched_flag & ~latch_clr) | live_rise;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      live_d_r <= 2'h0;
      o_input_loss_latched_flag <= 2'h0;
    end else if (i_clk_en) begin
      live_d_r <= o_input_loss_live_flag;
      o_input_loss_latched_flag <= latch_nxt;
    end
  end

  // Outputs lag the flags by one cycle so that they leave straight from flops.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_irq <= 1'b0;
      o_gpio_loss_n <= 1'b1;
    end else if (i_clk_en) begin
      o_irq <= |(o_input_loss_latched_flag & mask_r);
      if (gpio_irq_mode) begin
        o_gpio_loss_n <= ~|(o_input_loss_latched_flag & mask_r);
      end else begin
        o_gpio_loss_n <= ~|(o_input_loss_live_flag & ~input_monitor_disable);
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_live_rises(int i);
    i_clk_en && o_input_loss_live_flag[i] && !live_d_r[i];
  endsequence

  sequence s_no_clear(int i);
    !(wr_en && i_wb_adr == `RILM_OFS_LATCH && i_wb_sel[0] && i_wb_dat[i]);
  endsequence

  property p_latch_sets(int i);
    @(posedge i_clock) disable iff (i_srst)
      s_live_rises(i) |=> o_input_loss_latched_flag[i];
  endproperty

  property p_latch_holds(int i);
    @(posedge i_clock) disable iff (i_srst)
      (o_input_loss_latched_flag[i] and s_no_clear(i)) |=> o_input_loss_latched_flag[i];
  endproperty

  a_latch_sets0: assert property (p_latch_sets(0))
    else $error("latched flag 0 not set on loss");
  a_latch_sets1: assert property (p_latch_sets(1))
    else $error("latched flag 1 not set on loss");
  a_latch_holds0: assert property (p_latch_holds(0))
    else $error("latched flag 0 dropped without clear");
  a_latch_holds1: assert property (p_latch_holds(1))
    else $error("latched flag 1 dropped without clear");

  a_latch_rearm: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_clk_en && !o_input_loss_latched_flag[0] && o_input_loss_live_flag[0]
     && !live_d_r[0]) |=> o_input_loss_latched_flag[0])
    else $error("cleared flag did not take a new loss");

  a_gpio_level: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_clk_en && !gpio_irq_mode) |=>
      (o_gpio_loss_n == ~|($past(o_input_loss_live_flag) & $past(input_monitor_disable ^ 2'h3))))
    else $error("level output does not follow enabled losses");

  a_gpio_irq: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_clk_en && gpio_irq_mode) |=> (o_gpio_loss_n == !o_irq))
    else $error("interrupt output mode mismatch");

  a_pd_no_tick: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_clk_en && monitor_divider_powerdown) |=> !ref_tick_r)
    else $error("powered-down divider produced a tick");

  a_tick_spacing: assert property (@(posedge i_clock) disable iff (i_srst)
    (ref_tick_r && mondiv_lim > 16'h0001 && i_clk_en) |=> !ref_tick_r)
    else $error("divider tick too soon");

  a_ack_single: assert property (@(posedge i_clock) disable iff (i_srst)
    (o_wb_ack && i_clk_en) |=> !o_wb_ack)
    else $error("ack held for more than one cycle");

endmodule

// File: inc/rilm_params.svh
// Contract
// - Watch each input separately; static means inactive.
// - Compare pre-divided input against monitor divider.
// - Three missing edges mark input lost.
// - Live and latched loss flag per input.
// - Level output low on loss, high all active.
// - Loss may drive output as interrupt.
// - Per-input disable removes input from reporting; code clears live flag only, a flag already latched stays and can drive irq.
// - Largest divider ratio sets lowest monitored frequency.
// - Detection always compares against monitor divider.
// - Revalidate after configured consecutive good periods.
// - Cleared latched flag allows new event.
`ifndef RILM_PARAMS_SVH
`define RILM_PARAMS_SVH

// ==========================================================
// Timing
// ==========================================================
`define RILM_CLOCK_PERIOD_NS 4
`define RILM_MISS_LIMIT 2'h3
`define RILM_MONDIV_MAX_RATIO 17'h04000
`define RILM_MAX_INPUT_MHZ 250

// ==========================================================
// Register offsets
// ==========================================================
`define RILM_OFS_CTRL 8'h00
`define RILM_OFS_MONDIV 8'h04
`define RILM_OFS_PREDIV 8'h08
`define RILM_OFS_REVAL 8'h0C
`define RILM_OFS_STATUS 8'h10
`define RILM_OFS_LATCH 8'h14
`define RILM_OFS_MASK 8'h18

// ==========================================================
// Field positions
// ==========================================================
`define RILM_CTRL_DIS_LSB 0
`define RILM_CTRL_PD_BIT 2
`define RILM_CTRL_IRQMODE_BIT 3
`define RILM_PREDIV1_LSB 8

// ==========================================================
// Reset values
// ==========================================================
`define RILM_RST_CTRL 4'h4
`define RILM_RST_MONDIV 16'h0010
`define RILM_RST_PREDIV 16'h0101
`define RILM_RST_REVAL 8'h04
`define RILM_RST_MASK 2'h0

`endif

// File: inc/rilm_pkg.sv
package rilm_pkg;

  typedef enum logic [1:0] {
    RILM_ST_VALID = 2'b01,
    RILM_ST_LOST = 2'b10
  } rilm_state_e;

  // A zero ratio behaves as divide by one.
  function automatic logic [15:0] rilm_eff_ratio(input logic [15:0] r);
    rilm_eff_ratio = (r == 16'h0000) ? 16'h0001 : r;
  endfunction

  function automatic logic [31:0] rilm_lanes(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    rilm_lanes = res;
  endfunction

endpackage

// File: tb/rilm_ref_source.sv
`timescale 1ns/1ps
module rilm_ref_source (
  // Clock
  input wire logic i_clock,
  // Control
  input wire logic [1:0] i_run,
  input wire logic [7:0] i_half0,
  input wire logic [7:0] i_half1,
  // Reference levels
  output logic [1:0] o_level
);
  logic [7:0] cnt0_r = 8'h00;
  logic [7:0] cnt1_r = 8'h00;
  logic [1:0] lvl_r = 2'h0;
  assign o_level = lvl_r;
  // A stopped source holds its last level, because a static line is how a dead reference looks.
  always @(posedge i_clock) begin
    if (i_run[0]) begin
      cnt0_r <= (cnt0_r >= i_half0 - 8'h01) ? 8'h00 : cnt0_r + 8'h01;
      if (cnt0_r >= i_half0 - 8'h01) lvl_r[0] <= ~lvl_r[0];
    end
    if (i_run[1]) begin
      cnt1_r <= (cnt1_r >= i_half1 - 8'h01) ? 8'h00 : cnt1_r + 8'h01;
      if (cnt1_r >= i_half1 - 8'h01) lvl_r[1] <= ~lvl_r[1];
    end
  end
endmodule

// File: tb/tb_rilm_top.sv
`timescale 1ns/1ps
`include "rilm_params.svh"
module tb_rilm_top;
  import rilm_pkg::*;
  logic clk = 1'b0;
  logic i_srst = 1'b1;
  logic clk_en = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic ack;
  logic [1:0] refs;
  logic [1:0] live;
  logic [1:0] latched;
  logic irq;
  logic gpio_n;
  logic [1:0] run = 2'h0;
  logic [31:0] q;
  int n_errors = 0;
  int num_checks = 0;

  always #2 clk = ~clk;

  rilm_top u_dut (
    .i_clock(clk), .i_srst(i_srst), .i_clk_en(clk_en), .i_reference_input(refs),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(dat_w), .o_wb_dat(dat_r), .o_wb_ack(ack),
    .o_input_loss_live_flag(live), .o_input_loss_latched_flag(latched),
    .o_irq(irq), .o_gpio_loss_n(gpio_n)
  );

  // Input 1 runs twice as fast and is pre-divided by two, so both match the divider.
  rilm_ref_source u_src (
    .i_clock(clk), .i_run(run), .i_half0(8'h08), .i_half1(8'h04), .o_level(refs)
  );

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk("ack", 32'h1, {31'h0, ack});
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask

  task automatic flags(input logic [1:0] lv, input logic [1:0] lt, input logic i, input logic g);
    chk("live", {30'h0, lv}, {30'h0, live});
    chk("latched", {30'h0, lt}, {30'h0, latched});
    chk("irq", {31'h0, i}, {31'h0, irq});
    chk("gpio", {31'h0, g}, {31'h0, gpio_n});
  endtask

  task automatic wait_live(input logic [1:0] e, input int lim);
    for (int i = 0; i < lim; i++) begin
      if (live === e) break;
      @(posedge clk);
    end
    chk("live wait", {30'h0, e}, {30'h0, live});
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end

  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    repeat (2) @(posedge clk);
    i_srst <= 1'b0;
    rd(`RILM_OFS_CTRL, {28'h0, `RILM_RST_CTRL});
    rd(`RILM_OFS_MONDIV, {16'h0, `RILM_RST_MONDIV});
    rd(`RILM_OFS_PREDIV, {16'h0, `RILM_RST_PREDIV});
    rd(`RILM_OFS_REVAL, {24'h0, `RILM_RST_REVAL});
    rd(`RILM_OFS_MASK, {30'h0, `RILM_RST_MASK});
    rd(`RILM_OFS_STATUS, 32'h0);
    rd(8'h1C, 32'h0);
    flags(2'h0, 2'h0, 1'b0, 1'b1);
    wb(1'b1, `RILM_OFS_MONDIV, {15'h0, `RILM_MONDIV_MAX_RATIO});
    rd(`RILM_OFS_MONDIV, {15'h0, `RILM_MONDIV_MAX_RATIO});
    run <= 2'h3;
    wb(1'b1, `RILM_OFS_PREDIV, 32'h0201);
    wb(1'b1, `RILM_OFS_MONDIV, 32'h10);
    wb(1'b1, `RILM_OFS_MASK, 32'h3);
    wb(1'b1, `RILM_OFS_CTRL, 32'h0);
    repeat (200) @(posedge clk);
    flags(2'h0, 2'h0, 1'b0, 1'b1);
    // Input 0 dies; input 1 keeps running.
    run <= 2'h2;
    repeat (20) @(posedge clk);
    chk("live early", 32'h0, {30'h0, live});
    wait_live(2'h1, 120);
    repeat (3) @(posedge clk);
    flags(2'h1, 2'h1, 1'b1, 1'b0);
    rd(`RILM_OFS_STATUS, 32'h1);
    rd(`RILM_OFS_LATCH, 32'h1);
    run <= 2'h3;
    repeat (30) @(posedge clk);
    chk("live reval", 32'h1, {30'h0, live});
    wait_live(2'h0, 200);
    repeat (3) @(posedge clk);
    flags(2'h0, 2'h1, 1'b1, 1'b1);
    wb(1'b1, `RILM_OFS_LATCH, 32'h1);
    repeat (3) @(posedge clk);
    flags(2'h0, 2'h0, 1'b0, 1'b1);
    run <= 2'h2;
    wait_live(2'h1, 120);
    repeat (3) @(posedge clk);
    flags(2'h1, 2'h1, 1'b1, 1'b0);
    wb(1'b1, `RILM_OFS_CTRL, 32'h8);
    repeat (3) @(posedge clk);
    chk("gpio irq", 32'h0, {31'h0, gpio_n});
    wb(1'b1, `RILM_OFS_MASK, 32'h2);
    repeat (3) @(posedge clk);
    flags(2'h1, 2'h1, 1'b0, 1'b1);
    wb(1'b1, `RILM_OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    flags(2'h0, 2'h1, 1'b0, 1'b1);
    rd(`RILM_OFS_CTRL, 32'h1);
    run <= 2'h0;
    wait_live(2'h2, 120);
    repeat (3) @(posedge clk);
    flags(2'h2, 2'h3, 1'b1, 1'b0);
    wb(1'b1, `RILM_OFS_LATCH, 32'h3);
    repeat (3) @(posedge clk);
    flags(2'h2, 2'h0, 1'b0, 1'b0);
    // A low enable must freeze the monitors while input 1 comes back.
    clk_en <= 1'b0;
    run <= 2'h2;
    repeat (150) @(posedge clk);
    flags(2'h2, 2'h0, 1'b0, 1'b0);
    clk_en <= 1'b1;
    wait_live(2'h0, 200);
    report_and_stop();
  end
endmodule
